// file: core/dmabt_core.sv
`timescale 1ns/1ps
module dmabt_core (
	input wire logic core_clk, // system clock, 40 MHz
	input wire logic reset, // synchronous, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [dmabt_pkg::APB_AW-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic request_in_n, // external request pin, active low
	input wire logic serialTxDone, // serial unit transmit complete pulse
	input wire logic serialRxDone, // serial unit receive complete pulse
	input wire logic [5:0] timerMatchA, // timer channel 0-5 match/capture A pulses
	input wire logic nmi, // non-maskable interrupt pulse
	output logic busRequest, // request for the system bus
	input wire logic busGrant, // bus granted by bus controller
	output logic memValid, // memory access request
	output dmabt_pkg::dmabt_mem_s memOut, // access address, data, direction, size
	input wire logic memReady, // access completes this cycle
	input wire logic [15:0] memRdata, // read data
	output logic deadCycle, // dma dead cycle in progress
	output logic transfer_end_out_n, // transfer end output, active low
	output logic endIrq // transfer end interrupt request pulse
);
	// ****************************************
	// registers
	// ****************************************
	logic [23:0] sourceAddress;
	logic [23:0] destinationAddress;
	logic [7:0] blockSizeHold;
	logic [7:0] blockSizeCounter;
	logic [15:0] blockCount;
	dmabt_pkg::dmabt_band_s bandCtrl;
	dmabt_pkg::dmabt_chan_s chanCtrl;
	logic [23:0] srcStart;
	logic [23:0] dstStart;
	logic reqHeld;
	logic pinArmed;
	logic sampleEn;
	dmabt_pkg::dmabt_state_e state;
	dmabt_pkg::dmabt_state_e next_state;
	logic pinLevel;

	dmabt_pin_sync dmabt_pin_sync_i (
		.core_clk(core_clk),
		.reset(reset),
		.pinIn(request_in_n),
		.pinLevel(pinLevel)
	);

	// ****************************************
	// apb decode
	// ****************************************
	wire setupPhase = psel && !penable;
	wire accessPhase = psel && penable;
	wire hitSrc = (paddr == dmabt_pkg::OFS_SRC);
	wire hitDst = (paddr == dmabt_pkg::OFS_DST);
	wire hitHold = (paddr == dmabt_pkg::OFS_SIZE_HOLD);
	wire hitSize = (paddr == dmabt_pkg::OFS_SIZE_CNT);
	wire hitBlk = (paddr == dmabt_pkg::OFS_BLK_CNT);
	wire hitBand = (paddr == dmabt_pkg::OFS_BAND);
	wire hitChan = (paddr == dmabt_pkg::OFS_CHAN);
	wire hitStat = (paddr == dmabt_pkg::OFS_STATUS);
	wire mapped = hitSrc | hitDst | hitHold | hitSize | hitBlk | hitBand | hitChan | hitStat;
	wire wrEn = accessPhase && pwrite && mapped;

	wire [31:0] bandRead = {21'h00_0000, bandCtrl.endInterruptEnable, bandCtrl.masterEnable,
		bandCtrl.transferEnable, 5'h00, bandCtrl.tendEnable, bandCtrl.internalClearEnable,
		bandCtrl.fullAddressEnable};
	wire [31:0] chanRead = {20'h0_0000, chanCtrl.actSource, chanCtrl.burstMode, chanCtrl.destStepEnable,
		chanCtrl.destStepDirection, chanCtrl.sourceStepEnable, chanCtrl.sourceStepDirection,
		chanCtrl.dataSizeSelect, chanCtrl.blockSideSelect, chanCtrl.blockEnable};
	wire [31:0] statRead = {24'h00_0000, reqHeld, pinArmed, state};
	wire [31:0] readMux = hitSrc ? {8'h00, sourceAddress} :
		hitDst ? {8'h00, destinationAddress} :
		hitHold ? {24'h00_0000, blockSizeHold} :
		hitSize ? {24'h00_0000, blockSizeCounter} :
		hitBlk ? {16'h0000, blockCount} :
		hitBand ? bandRead :
		hitChan ? chanRead :
		hitStat ? statRead : dmabt_pkg::RD_ZERO;

	// every register answers in its access cycle; unmapped offsets flag an error
	assign pready = 1'b1;
	assign pslverr = accessPhase && !mapped;

	// ****************************************
	// mode and request selection
	// ****************************************
	wire blockMode = bandCtrl.fullAddressEnable && chanCtrl.blockEnable;
	wire fullMode = bandCtrl.fullAddressEnable;
	wire running = bandCtrl.transferEnable && bandCtrl.masterEnable && fullMode;
	wire [3:0] actSel = chanCtrl.actSource;
	// one compare per timer channel
	logic [$bits(timerMatchA)-1:0] timerPick;
	for (genvar t = 0; t < $bits(timerMatchA); t++) begin : g_timer
		assign timerPick[t] = (actSel == (dmabt_pkg::ACT_TMR0 + 4'(t))) && timerMatchA[t];
	end
	wire timerHit = |timerPick;
	// internal activation sources
	wire internalReq = ((actSel == dmabt_pkg::ACT_SER_TX) && serialTxDone) ||
		((actSel == dmabt_pkg::ACT_SER_RX) && serialRxDone) || timerHit;
	wire pinSel = (actSel == dmabt_pkg::ACT_PIN);
	wire edgeMode = bandCtrl.internalClearEnable;
	wire accepting = running && sampleEn && (state == dmabt_pkg::ST_IDLE);
	wire pinLow = !pinLevel;
	// edge mode requires the pin to be seen high again before a new low counts
	wire pinReq = pinSel && pinLow && (edgeMode ? pinArmed : 1'b1);
	// a held request leaves idle only while the channel runs
	wire activate = (state == dmabt_pkg::ST_IDLE) && running && reqHeld;
	// nmi reaches only a burst channel; a block channel ignores it and keeps running
	wire nmiStop = nmi && bandCtrl.transferEnable && chanCtrl.burstMode && !blockMode;

	// ****************************************
	// address stepping
	// ****************************************
	// word items step addresses by two, byte items by one
	wire [23:0] stepSize = chanCtrl.dataSizeSelect ? dmabt_pkg::STEP_WORD : dmabt_pkg::STEP_BYTE;
	wire [23:0] srcStepped = !chanCtrl.sourceStepEnable ? sourceAddress :
		chanCtrl.sourceStepDirection ? sourceAddress - stepSize : sourceAddress + stepSize;
	wire [23:0] dstStepped = !chanCtrl.destStepEnable ? destinationAddress :
		chanCtrl.destStepDirection ? destinationAddress - stepSize :
		destinationAddress + stepSize;
	wire [7:0] sizeDec = blockSizeCounter - dmabt_pkg::SIZE_ONE;
	// a loaded zero stands for the full range: decrement first, then test
	wire [15:0] countDec = blockCount - dmabt_pkg::CNT_ONE;
	wire writeDone = (state == dmabt_pkg::ST_WRITE) && memReady;
	wire blockEnd = blockMode && (sizeDec == 8'h00);
	wire countZero = (countDec == 16'h0000);
	wire transferEnd = blockMode ? (blockEnd && countZero) : countZero;
	// block end restores the block side to the block's start address
	wire restoreSrc = blockEnd && chanCtrl.blockSideSelect;
	wire restoreDst = blockEnd && !chanCtrl.blockSideSelect;
	wire [23:0] next_src = restoreSrc ? srcStart : srcStepped;
	wire [23:0] next_dst = restoreDst ? dstStart : dstStepped;
	// burst continues only while master enable stays set
	wire burstGo = !blockMode && chanCtrl.burstMode && bandCtrl.masterEnable;
	wire continueRead = blockMode ? !blockEnd : (!countZero && burstGo);

	// ****************************************
	// transfer sequencer
	// ****************************************
	always_comb begin
		next_state = state;
		case (state)
			dmabt_pkg::ST_IDLE: begin
				if (activate) begin
					next_state = dmabt_pkg::ST_BUSREQ;
				end
			end
			dmabt_pkg::ST_BUSREQ: begin
				if (busGrant) begin
					next_state = dmabt_pkg::ST_READ;
				end
			end
			dmabt_pkg::ST_READ: begin
				// bus is held from read straight into write
				if (memReady) begin
					next_state = dmabt_pkg::ST_WRITE;
				end
			end
			dmabt_pkg::ST_WRITE: begin
				if (memReady) begin
					if (transferEnd || blockEnd) begin
						next_state = dmabt_pkg::ST_DEAD;
					end else if (continueRead) begin
						next_state = dmabt_pkg::ST_READ;
					end else begin
						next_state = dmabt_pkg::ST_RELEASE;
					end
				end
			end
			// dead cycle and release each last exactly one state
			dmabt_pkg::ST_DEAD: begin
				next_state = dmabt_pkg::ST_RELEASE;
			end
			dmabt_pkg::ST_RELEASE: begin
				next_state = dmabt_pkg::ST_IDLE;
			end
			default: begin
				next_state = dmabt_pkg::ST_IDLE;
			end
		endcase
	end

	// the bus stays requested from the request state through the dead cycle
	assign busRequest = (state == dmabt_pkg::ST_BUSREQ) || (state == dmabt_pkg::ST_READ) ||
		(state == dmabt_pkg::ST_WRITE) || (state == dmabt_pkg::ST_DEAD);
	assign memValid = (state == dmabt_pkg::ST_READ) || (state == dmabt_pkg::ST_WRITE);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= dmabt_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// bus access outputs
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			memOut <= '0;
			deadCycle <= 1'b0;
			transfer_end_out_n <= 1'b1;
			endIrq <= 1'b0;
		end else begin
			deadCycle <= writeDone && (transferEnd || blockEnd);
			// active low during the end cycle when its output is enabled
			transfer_end_out_n <= !(writeDone && transferEnd && bandCtrl.tendEnable);
			endIrq <= writeDone && transferEnd && bandCtrl.endInterruptEnable;
			// each access launches on the edge that ends the previous state and stands until ready
			memOut.word <= chanCtrl.dataSizeSelect;
			if ((state == dmabt_pkg::ST_BUSREQ) && busGrant) begin
				memOut.addr <= sourceAddress;
				memOut.write <= 1'b0;
			end else if ((state == dmabt_pkg::ST_READ) && memReady) begin
				memOut.wdata <= memRdata;
				memOut.addr <= destinationAddress;
				memOut.write <= 1'b1;
			end else if (writeDone) begin
				memOut.addr <= next_src;
				memOut.write <= 1'b0;
			end
		end
	end

	// ****************************************
	// request capture
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			reqHeld <= 1'b0;
			pinArmed <= 1'b0;
			sampleEn <= 1'b0;
		end else begin
			// sampling starts the edge after transfer enable is written
			sampleEn <= bandCtrl.transferEnable;
			if (!sampleEn) begin
				pinArmed <= 1'b0;
			end else if (pinLevel) begin
				pinArmed <= 1'b1;
			end else if (activate) begin
				pinArmed <= 1'b0;
			end
			if (!running) begin
				reqHeld <= 1'b0;
			end else if (activate) begin
				// activation consumes the held request before any new sample counts
				reqHeld <= 1'b0;
			end else if (accepting && (pinReq || internalReq)) begin
				reqHeld <= 1'b1;
			end
		end
	end

	// ****************************************
	// register file and counters
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (reset) begin
			sourceAddress <= 24'h00_0000;
			destinationAddress <= 24'h00_0000;
			blockSizeHold <= 8'h00;
			blockSizeCounter <= 8'h00;
			blockCount <= 16'h0000;
			bandCtrl <= '0;
			chanCtrl <= '0;
			srcStart <= 24'h00_0000;
			dstStart <= 24'h00_0000;
			prdata <= dmabt_pkg::RD_ZERO;
		end else begin
			// read data is taken in the setup cycle and stands through the access
			if (setupPhase) begin
				prdata <= readMux;
			end
			// block start addresses are captured as each block begins
			if (activate && blockMode) begin
				srcStart <= sourceAddress;
				dstStart <= destinationAddress;
			end
			if (writeDone) begin
				sourceAddress <= next_src;
				destinationAddress <= next_dst;
				if (blockMode) begin
					blockSizeCounter <= blockEnd ? blockSizeHold : sizeDec;
					if (blockEnd) begin
						blockCount <= countDec;
					end
				end else begin
					blockCount <= countDec;
				end
				if (transferEnd) begin
					bandCtrl.transferEnable <= 1'b0;
				end
			end
			// a burst channel loses master enable on nmi; a block runs to its end
			if (nmiStop) begin
				bandCtrl.masterEnable <= 1'b0;
			end
			if (wrEn && hitSrc) begin
				sourceAddress <= pwdata[23:0];
			end
			if (wrEn && hitDst) begin
				destinationAddress <= pwdata[23:0];
			end
			if (wrEn && hitHold) begin
				blockSizeHold <= pwdata[7:0];
			end
			if (wrEn && hitSize) begin
				blockSizeCounter <= pwdata[7:0];
			end
			if (wrEn && hitBlk) begin
				blockCount <= pwdata[15:0];
			end
			if (wrEn && hitBand) begin
				bandCtrl.fullAddressEnable <= pwdata[dmabt_pkg::BAND_FAE];
				bandCtrl.internalClearEnable <= pwdata[dmabt_pkg::BAND_ICE];
				bandCtrl.tendEnable <= pwdata[dmabt_pkg::BAND_TRANSFER_END_OUT_N_EN];
				bandCtrl.transferEnable <= pwdata[dmabt_pkg::BAND_TE];
				bandCtrl.masterEnable <= pwdata[dmabt_pkg::BAND_ME];
				bandCtrl.endInterruptEnable <= pwdata[dmabt_pkg::BAND_EIE];
			end
			if (wrEn && hitChan) begin
				chanCtrl.blockEnable <= pwdata[dmabt_pkg::CH_BLK];
				chanCtrl.blockSideSelect <= pwdata[dmabt_pkg::CH_SIDE];
				chanCtrl.dataSizeSelect <= pwdata[dmabt_pkg::CH_WORD];
				chanCtrl.sourceStepDirection <= pwdata[dmabt_pkg::CH_SDIR];
				chanCtrl.sourceStepEnable <= pwdata[dmabt_pkg::CH_SEN];
				chanCtrl.destStepDirection <= pwdata[dmabt_pkg::CH_DDIR];
				chanCtrl.destStepEnable <= pwdata[dmabt_pkg::CH_DEN];
				chanCtrl.burstMode <= pwdata[dmabt_pkg::CH_BURST];
				chanCtrl.actSource <= pwdata[dmabt_pkg::CH_SRC_LO +: 4];
			end
		end
	end
endmodule

// file: core/dmabt_pkg.sv
package dmabt_pkg;

	localparam int ADDR_W = 24;
	localparam int APB_AW = 8;

	// register byte addresses
	localparam logic [7:0] OFS_SRC = 8'h00;
	localparam logic [7:0] OFS_DST = 8'h04;
	localparam logic [7:0] OFS_SIZE_HOLD = 8'h08;
	localparam logic [7:0] OFS_SIZE_CNT = 8'h0C;
	localparam logic [7:0] OFS_BLK_CNT = 8'h10;
	localparam logic [7:0] OFS_BAND = 8'h14;
	localparam logic [7:0] OFS_CHAN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// band control field positions
	localparam int BAND_FAE = 0;
	localparam int BAND_ICE = 1;
	localparam int BAND_TRANSFER_END_OUT_N_EN = 2;
	localparam int BAND_TE = 8;
	localparam int BAND_ME = 9;
	localparam int BAND_EIE = 10;

	// channel control field positions
	localparam int CH_BLK = 0;
	localparam int CH_SIDE = 1;
	localparam int CH_WORD = 2;
	localparam int CH_SDIR = 3;
	localparam int CH_SEN = 4;
	localparam int CH_DDIR = 5;
	localparam int CH_DEN = 6;
	localparam int CH_BURST = 7;
	localparam int CH_SRC_LO = 8;

	// activation source codes
	localparam logic [3:0] ACT_PIN = 4'h0;
	localparam logic [3:0] ACT_SER_TX = 4'h1;
	localparam logic [3:0] ACT_SER_RX = 4'h2;
	localparam logic [3:0] ACT_TMR0 = 4'h3;
	localparam logic [3:0] ACT_TMR5 = 4'h8;

	localparam logic [23:0] STEP_BYTE = 24'h00_0001;
	localparam logic [23:0] STEP_WORD = 24'h00_0002;
	localparam logic [7:0] SIZE_ONE = 8'h01;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic fullAddressEnable;
		logic internalClearEnable;
		logic tendEnable;
		logic transferEnable;
		logic masterEnable;
		logic endInterruptEnable;
	} dmabt_band_s;

	typedef struct packed {
		logic blockEnable;
		logic blockSideSelect;
		logic dataSizeSelect;
		logic sourceStepDirection;
		logic sourceStepEnable;
		logic destStepDirection;
		logic destStepEnable;
		logic burstMode;
		logic [3:0] actSource;
	} dmabt_chan_s;

	typedef struct packed {
		logic [23:0] addr;
		logic [15:0] wdata;
		logic write;
		logic word;
	} dmabt_mem_s;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_BUSREQ = 6'b00_0010,
		ST_READ = 6'b00_0100,
		ST_WRITE = 6'b00_1000,
		ST_DEAD = 6'b01_0000,
		ST_RELEASE = 6'b10_0000
	} dmabt_state_e;

endpackage

// file: core/dmabt_pin_sync.sv
`timescale 1ns/1ps
module dmabt_pin_sync (
	input wire logic core_clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic pinIn, // asynchronous pin level
	output logic pinLevel // filtered level
);
	logic stage1;
	logic stage2;
	logic stage3;

	// a change counts once the second and third stages agree
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stage1 <= 1'b1;
			stage2 <= 1'b1;
			stage3 <= 1'b1;
			pinLevel <= 1'b1;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3) begin
				pinLevel <= stage3;
			end
		end
	end
endmodule

// file: verif/dmabt_core_monitor.sv
`timescale 1ns/1ps
// ************************************
// checker on the memory link outputs
// ************************************
module dmabt_core_monitor (
	input wire logic core_clk, // clock
	input wire logic reset, // sync reset
	input wire logic busRequest, // bus request
	input wire logic memValid, // access valid
	input wire dmabt_pkg::dmabt_mem_s memOut, // access
	input wire logic memReady, // access done
	input wire logic [15:0] memRdata, // read data
	input wire logic deadCycle, // dead cycle
	input wire logic transfer_end_out_n, // end output
	input wire logic endIrq // end interrupt
);
	logic [15:0] rdSeen;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	always_ff @(posedge core_clk) begin
		if (memValid && !memOut.write && memReady) begin
			rdSeen <= memRdata;
		end
	end
	a_bus_held: assert property (memValid |-> busRequest && $past(busRequest))
		else $error("access without bus request");
	a_read_then_write: assert property (memValid && !memOut.write && memReady |=> memValid && memOut.write)
		else $error("read not followed by write");
	a_write_data: assert property (memValid && memOut.write |-> memOut.wdata == rdSeen)
		else $error("write data differs from read data");
	a_access_stands: assert property (memValid && !memReady |=> memValid && $stable(memOut))
		else $error("access changed before ready");
	a_dead_after_write: assert property ($rose(deadCycle) |-> $past(memValid && memOut.write && memReady))
		else $error("dead cycle not after write");
	a_dead_release: assert property (deadCycle |=> !deadCycle && !busRequest)
		else $error("dead cycle not one state then release");
	a_transfer_end_out_n_in_dead: assert property (!transfer_end_out_n |-> deadCycle)
		else $error("end output outside dead cycle");
	a_irq_in_dead: assert property (endIrq |-> deadCycle && $past(memOut.write))
		else $error("end interrupt outside end cycle");
endmodule

// file: verif/dmabt_bus_model.sv
`timescale 1ns/1ps
// ************************************
// bus controller and memory beside the channel
// ************************************
module dmabt_bus_model (
	input wire logic core_clk, // clock
	input wire logic reset, // sync reset
	input wire logic busRequest, // channel wants the bus
	input wire logic memValid, // access request
	input wire dmabt_pkg::dmabt_mem_s memOut, // access
	output logic busGrant, // bus handed over
	output logic memReady, // access ends
	output logic [15:0] memRdata // read data
);
	wire logic [7:0] lo = memOut.addr[7:0];
	// scrambled outside a finished access so stale data is never trusted
	assign memRdata = memReady ? {lo, ~lo} : {~lo, lo};
	always_ff @(posedge core_clk) begin
		if (reset) begin
			busGrant <= 1'b0;
			memReady <= 1'b0;
		end else begin
			busGrant <= busRequest && (busGrant || 1'($urandom));
			memReady <= memValid && !memReady && 1'($urandom);
		end
	end
endmodule

// file: verif/dmabt_core_test.sv
`timescale 1ns/1ps
module dmabt_core_test;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, request_in_n = 1'b1;
	logic serialTxDone = 1'b0, serialRxDone = 1'b0, nmi = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdVal;
	logic [5:0] timerMatchA = 6'h00;
	logic edgeSel = 1'b1, expWord = 1'b0;
	logic pready, pslverr, busRequest, busGrant, memValid, memReady, deadCycle, transfer_end_out_n, endIrq, lastErr;
	logic [15:0] memRdata;
	dmabt_pkg::dmabt_mem_s memOut;
	logic [39:0] expQ[$];
	int errors = 0, comparisons = 0, irqs = 0, busRises = 0, b;
	always #12.5 core_clk = ~core_clk;
	dmabt_core dmabt_core_i (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .request_in_n, .serialTxDone, .serialRxDone, .timerMatchA, .nmi, .busRequest, .busGrant,
		.memValid, .memOut, .memReady, .memRdata, .deadCycle, .transfer_end_out_n, .endIrq);
	dmabt_bus_model dmabt_bus_model_i (.core_clk, .reset, .busRequest, .memValid, .memOut, .busGrant,
		.memReady, .memRdata);
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// ************************************
	// result watcher
	// ************************************
	always @(posedge core_clk) begin
		if (!reset && memValid === 1'b1 && memOut.write === 1'b1 && memReady === 1'b1) begin
			chk({memOut.addr, memOut.wdata}, expQ.size() > 0 ? expQ.pop_front() : 40'hxx_xxxx_xxxx);
			chk(40'(memOut.word), 40'(expWord));
		end
		if (endIrq === 1'b1 && transfer_end_out_n === 1'b0) irqs++;
		if ($rose(busRequest)) busRises++;
	end
	// ************************************
	// drivers
	// ************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rdVal = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk({8'h00, rdVal}, {8'h00, e});
	endtask
	task automatic trig(input logic [3:0] act, input logic hit);
		@(posedge core_clk);
		case (act)
			4'h0: request_in_n <= 1'b0;
			4'h1: serialTxDone <= 1'b1;
			4'h2: serialRxDone <= 1'b1;
			default: timerMatchA[act - 4'h3] <= 1'b1;
		endcase
		@(posedge core_clk);
		serialTxDone <= 1'b0;
		serialRxDone <= 1'b0;
		timerMatchA <= 6'h00;
		nmi <= hit;
		@(posedge core_clk);
		nmi <= 1'b0;
	endtask
	task automatic wait_release(input logic stop);
		int k;
		for (k = 0; k < 300 && busRequest !== 1'b1; k++) @(posedge core_clk);
		chk(40'(busRequest === 1'b1), 40'(!stop));
		request_in_n <= 1'b1;
		while (busRequest !== 1'b0) @(posedge core_clk);
		repeat (6) @(posedge core_clk);
	endtask
	task automatic run(input logic blk, brst, side, word, input logic [3:0] act, input int m, n, input logic stop);
		logic [23:0] s, d, s0, d0, st, ss, ds;
		logic sdir, sen, ddir, den;
		int reqs, per;
		s = 24'($urandom);
		d = 24'($urandom);
		{sdir, sen, ddir, den} = 4'($urandom);
		st = word ? 24'h00_0002 : 24'h00_0001;
		ss = sen ? (sdir ? -st : st) : 24'h00_0000;
		ds = den ? (ddir ? -st : st) : 24'h00_0000;
		reqs = (blk || !brst) ? n : 1;
		per = blk ? m : (brst ? n : 1);
		irqs = 0;
		expWord = word;
		apb(1'b1, dmabt_pkg::OFS_BAND, 32'h0000_0000);
		rd(dmabt_pkg::OFS_BAND, 32'h0000_0000);
		apb(1'b1, dmabt_pkg::OFS_SRC, {8'h00, s});
		apb(1'b1, dmabt_pkg::OFS_DST, {8'h00, d});
		apb(1'b1, dmabt_pkg::OFS_SIZE_HOLD, {24'h00_0000, m[7:0]});
		apb(1'b1, dmabt_pkg::OFS_SIZE_CNT, {24'h00_0000, m[7:0]});
		apb(1'b1, dmabt_pkg::OFS_BLK_CNT, {16'h0000, n[15:0]});
		apb(1'b1, dmabt_pkg::OFS_CHAN, {20'h0_0000, act, brst, den, ddir, sen, sdir, word, side, blk});
		apb(1'b1, dmabt_pkg::OFS_BAND, {21'h00_0000, 3'b111, 5'h00, 1'b1, edgeSel, 1'b1});
		if (stop) begin
			nmi <= 1'b1;
			@(posedge core_clk);
			nmi <= 1'b0;
			per = 0;
		end
		for (int r = 0; r < reqs; r++) begin
			s0 = s;
			d0 = d;
			for (int i = 0; i < per; i++) begin
				expQ.push_back({d, s[7:0], ~s[7:0]});
				s += ss;
				d += ds;
			end
			if (blk && side) s = s0;
			if (blk && !side) d = d0;
			trig(act, blk);
			wait_release(stop);
		end
		chk(40'(expQ.size()), 40'h00_0000_0000);
		rd(dmabt_pkg::OFS_BAND, {21'h00_0000, (stop ? 3'b101 : 3'b110), 5'h00, 1'b1, edgeSel, 1'b1});
		chk(40'(irqs), stop ? 40'h00_0000_0000 : 40'h00_0000_0001);
		if (blk) rd(dmabt_pkg::OFS_SIZE_CNT, {24'h00_0000, m[7:0]});
		$display("run done act=%0d blk=%0d burst=%0d", act, blk, brst);
	endtask
	// ************************************
	// main sequence
	// ************************************
	initial begin
		void'($urandom(87));
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		for (int a = 0; a < 7; a++) rd(8'(a * 4), 32'h0000_0000);
		apb(1'b1, dmabt_pkg::OFS_SRC, 32'hFFFF_FFFF);
		rd(dmabt_pkg::OFS_SRC, 32'h00FF_FFFF);
		rd(8'h24, 32'h0000_0000);
		chk({39'h00_0000_0000, lastErr}, 40'h00_0000_0001);
		$display("registers done");
		b = busRises;
		apb(1'b1, dmabt_pkg::OFS_CHAN, 32'h0000_0301);
		apb(1'b1, dmabt_pkg::OFS_BAND, 32'h0000_0706);
		trig(4'h3, 1'b0);
		repeat (20) @(posedge core_clk);
		chk(40'(busRises), 40'(b));
		$display("mode gate done");
		for (int a = 0; a < 9; a++) run(1'b1, 1'b0, a[0], a[1], 4'(a), 2, 2, 1'b0);
		edgeSel = 1'b0;
		run(1'b1, 1'b0, 1'b0, 1'b1, 4'h0, 3, 2, 1'b0);
		edgeSel = 1'b1;
		run(1'b1, 1'b0, 1'b1, 1'b0, 4'h4, 256, 1, 1'b0);
		run(1'b0, 1'b0, 1'b0, 1'b1, 4'h5, 1, 3, 1'b0);
		run(1'b0, 1'b1, 1'b0, 1'b1, 4'h6, 1, 4, 1'b0);
		run(1'b0, 1'b1, 1'b0, 1'b0, 4'h7, 1, 3, 1'b1);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		end_of_test();
	end
endmodule
bind dmabt_core dmabt_core_monitor dmabt_core_monitor_i (.core_clk, .reset, .busRequest, .memValid, .memOut,
	.memReady, .memRdata, .deadCycle, .transfer_end_out_n, .endIrq);
